/* inc/ept_pkg.sv */
// Constants, register map and field layouts for the compare/PWM timer
package ept_pkg;

  // Counter and compare width
  localparam int unsigned CNT_W = 10;
  localparam int unsigned PRE_W = 8;
  localparam int unsigned TOP_W = CNT_W + 1;

  // APB register byte offsets
  localparam logic [11:0] OFS_CTRL_A = 12'h000;
  localparam logic [11:0] OFS_CTRL_B = 12'h004;
  localparam logic [11:0] OFS_CMP_A = 12'h008;
  localparam logic [11:0] OFS_CMP_B = 12'h00c;
  localparam logic [11:0] OFS_COUNT = 12'h010;
  localparam logic [11:0] OFS_FLAGS = 12'h014;
  localparam logic [11:0] OFS_PRESC = 12'h018;
  localparam logic [11:0] OFS_PINS = 12'h01c;

  // Mode selection pair encodings
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  // Pin action encodings, compare output mode
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Pin action encodings, PWM mode
  localparam logic [1:0] PACT_INACTIVE = 2'h0;
  localparam logic [1:0] PACT_ACTIVE = 2'h1;
  localparam logic [1:0] PACT_WAVE = 2'h2;
  localparam logic [1:0] PACT_PULSE = 2'h3;

  // Alignment encodings
  localparam logic [1:0] ALN_EDGE = 2'h0;
  localparam logic [1:0] ALN_UP = 2'h1;
  localparam logic [1:0] ALN_DOWN = 2'h2;
  localparam logic [1:0] ALN_BOTH = 2'h3;

  // Period field steps of 128; an all-zero field means the full range
  localparam int unsigned PSTEP_SHIFT = 7;
  localparam logic [TOP_W-1:0] EDGE_FULL = 11'h400;
  localparam logic [TOP_W-1:0] CENTRE_FULL = 11'h3ff;

  // First control word, bit 0 upward: run, mode, action, init, invert,
  // clear select, period field
  typedef struct packed {
    logic [2:0] period_field;
    logic counter_clear_select;
    logic pin_a_invert;
    logic pin_a_initial_level;
    logic [1:0] pin_a_action;
    logic [1:0] compare_a_mode_pair;
    logic timer_run_enable;
  } ept_ctrl_a_t;

  // Second control word, bit 0 upward: mode, action, init, invert, align
  typedef struct packed {
    logic [1:0] pwm_align_select;
    logic pin_b_invert;
    logic pin_b_initial_level;
    logic [1:0] pin_b_action;
    logic [1:0] compare_b_mode_pair;
  } ept_ctrl_b_t;

  // Sticky match flags, bit 0 = A, bit 1 = B, bit 2 = P
  typedef struct packed {
    logic match_p_flag;
    logic match_b_flag;
    logic match_a_flag;
  } ept_flags_t;

  // Pin drive bundle
  typedef struct packed {
    logic output_pin_a;
    logic pin_a_oe;
    logic [2:0] output_pins_b;
    logic pins_b_oe;
  } ept_pins_t;

  localparam int unsigned CTRL_A_W = 11;
  localparam int unsigned CTRL_B_W = 8;
  localparam int unsigned FLAGS_W = 3;
  localparam logic [CTRL_A_W-1:0] CTRL_A_RST = 11'h000;
  localparam logic [CTRL_B_W-1:0] CTRL_B_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RST = 10'h000;
  localparam logic [PRE_W-1:0] PRESC_RST = 8'h00;

endpackage : ept_pkg

/* rtl/ept_timer.sv */
// Compare-match, timer/counter and PWM timer with an APB register slave
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ept_timer (
  input wire logic pclk, // 100 MHz bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high = write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output ept_pkg::ept_pins_t pins // Pin levels and enables
);
  import ept_pkg::*;

  ept_ctrl_a_t ctrl_a_r;
  ept_ctrl_b_t ctrl_b_r;
  logic [CNT_W-1:0] cmp_a_r;
  logic [CNT_W-1:0] cmp_b_r;
  logic [PRE_W-1:0] presc_r;
  logic [PRE_W-1:0] pre_cnt_r;
  ept_flags_t flags_r;
  ept_flags_t flags_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic dir_down_r;
  logic run_d_r;
  logic st_a_r;
  logic st_b_r;
  ept_pins_t pins_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic mode_cmp, mode_tmr, mode_pwm, centre, run, tick, run_rise;
  logic wr_en, setup, mapped;
  logic [TOP_W-1:0] top, ptop;
  logic a_hit, b_hit, p_hit, edge_end, up_ok, down_ok, dir_ok;
  logic ev_a, ev_b, ev_p;
  logic wave_a, wave_b;

  // Period from the 3-bit field; zero selects the full range
  function automatic logic [TOP_W-1:0] field_top(input logic [2:0] pf,
                                                 input logic ctr);
    if (pf == 3'h0) begin
      field_top = ctr ? CENTRE_FULL : EDGE_FULL;
    end else begin
      field_top = {1'b0, pf, 7'h00}; // steps of 1 << PSTEP_SHIFT
    end
  endfunction : field_top

  // Compare-mode pin action on a match
  function automatic logic cmp_action(input logic [1:0] act,
                                      input logic cur);
    case (act)
      ACT_LOW: cmp_action = 1'b0;
      ACT_HIGH: cmp_action = 1'b1;
      ACT_TOGGLE: cmp_action = ~cur;
      default: cmp_action = cur;
    endcase
  endfunction : cmp_action

  // PWM pin level; single pulse is not supported and reads inactive
  function automatic logic pwm_level(input logic [1:0] act,
                                     input logic act_hi, input logic wave,
                                     input logic inv);
    logic lvl;
    lvl = ~act_hi;
    case (act)
      PACT_ACTIVE: lvl = act_hi;
      PACT_WAVE: lvl = wave ? act_hi : ~act_hi;
      default: lvl = ~act_hi;
    endcase
    pwm_level = lvl ^ inv;
  endfunction : pwm_level

  // Mode decode; mismatched or capture pairs let the counter run but set no flags and drive no pins
  assign mode_cmp = (ctrl_a_r.compare_a_mode_pair == MODE_CMP) &&
                    (ctrl_b_r.compare_b_mode_pair == MODE_CMP);
  assign mode_tmr = (ctrl_a_r.compare_a_mode_pair == MODE_TMR) &&
                    (ctrl_b_r.compare_b_mode_pair == MODE_TMR);
  assign mode_pwm = (ctrl_a_r.compare_a_mode_pair == MODE_PWM) &&
                    (ctrl_b_r.compare_b_mode_pair == MODE_PWM);
  assign centre = mode_pwm && (ctrl_b_r.pwm_align_select != ALN_EDGE);
  assign run = ctrl_a_r.timer_run_enable;
  assign run_rise = run && !run_d_r;

  // Timer tick: one pulse every presc_r+1 bus clocks while running
  assign tick = run && (pre_cnt_r == presc_r);

  // Period limits and comparators
  assign ptop = field_top(ctrl_a_r.period_field, centre);
  assign top = ctrl_a_r.counter_clear_select ? {1'b0, cmp_a_r} : ptop;
  assign a_hit = (cnt_r == cmp_a_r);
  assign b_hit = (cnt_r == cmp_b_r);
  assign p_hit = ({1'b0, cnt_r} == ptop - 11'h001);
  assign edge_end = ({1'b0, cnt_r} == top - 11'h001);
  assign up_ok = (ctrl_b_r.pwm_align_select == ALN_UP) ||
                 (ctrl_b_r.pwm_align_select == ALN_BOTH);
  assign down_ok = (ctrl_b_r.pwm_align_select == ALN_DOWN) ||
                   (ctrl_b_r.pwm_align_select == ALN_BOTH);
  assign dir_ok = !centre || (dir_down_r ? down_ok : up_ok);

  // Match events, one per tick
  // Edge PWM clearing on A wraps one short of compare A, so that wrap is
  // its A match; without it the A flag would never rise in that mode
  assign ev_a = tick && dir_ok && (mode_cmp || mode_tmr || mode_pwm) &&
                (a_hit || (mode_pwm && !centre &&
                 ctrl_a_r.counter_clear_select && edge_end));
  assign ev_b = tick && b_hit && dir_ok && (mode_cmp || mode_tmr ||
                mode_pwm);
  // Centre mode raises P at the bottom whatever the clear select says
  assign ev_p = tick && ((!ctrl_a_r.counter_clear_select && (
                ((mode_cmp || mode_tmr) && p_hit) ||
                (mode_pwm && !centre && edge_end))) ||
                (centre && dir_down_r && cnt_r <= 10'h001));

  // Waveforms keep running whatever the pin action says
  assign wave_a = (cnt_r < cmp_a_r) || ({1'b0, cmp_a_r} >= top);
  assign wave_b = (cnt_r < cmp_b_r) || ({1'b0, cmp_b_r} >= top);

  // Bus decode: every access is setup plus one ready access cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_r;
  assign mapped = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);

  // Ready rises in the access cycle that follows each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
    end
  end

  // Read data is captured in setup so it stands during the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        OFS_CTRL_A: prdata_r <= {21'h000000, ctrl_a_r};
        OFS_CTRL_B: prdata_r <= {24'h000000, ctrl_b_r};
        OFS_CMP_A: prdata_r <= {22'h000000, cmp_a_r};
        OFS_CMP_B: prdata_r <= {22'h000000, cmp_b_r};
        OFS_COUNT: prdata_r <= {21'h000000, dir_down_r, cnt_r};
        OFS_FLAGS: prdata_r <= {29'h00000000, flags_r};
        OFS_PRESC: prdata_r <= {24'h000000, presc_r};
        OFS_PINS: prdata_r <= {26'h0000000, pins_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r <= CTRL_A_RST;
      ctrl_b_r <= CTRL_B_RST;
      cmp_a_r <= CMP_RST;
      cmp_b_r <= CMP_RST;
      presc_r <= PRESC_RST;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL_A: ctrl_a_r <= pwdata[CTRL_A_W-1:0];
        OFS_CTRL_B: ctrl_b_r <= pwdata[CTRL_B_W-1:0];
        OFS_CMP_A: cmp_a_r <= pwdata[CNT_W-1:0];
        OFS_CMP_B: cmp_b_r <= pwdata[CNT_W-1:0];
        OFS_PRESC: presc_r <= pwdata[PRE_W-1:0];
        default: ;
      endcase
    end
  end

  // Flags are write-one-to-clear; a match in the clearing cycle wins
  always_comb begin
    flags_nxt = flags_r;
    if (wr_en && paddr == OFS_FLAGS) begin
      flags_nxt = flags_r & ~ept_flags_t'(pwdata[FLAGS_W-1:0]);
    end
    if (ev_a) flags_nxt.match_a_flag = 1'b1;
    if (ev_b) flags_nxt.match_b_flag = 1'b1;
    if (ev_p) flags_nxt.match_p_flag = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= ept_flags_t'(3'h0);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Prescaler and run-edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 8'h00;
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run;
      if (!run || tick) begin
        pre_cnt_r <= 8'h00;
      end else begin
        pre_cnt_r <= pre_cnt_r + 8'h01;
      end
    end
  end

  // Counter: restarts from zero on each run rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 10'h000;
      dir_down_r <= 1'b0;
    end else if (run_rise) begin
      cnt_r <= 10'h000;
      dir_down_r <= 1'b0;
    end else if (tick) begin
      if (centre) begin
        if (dir_down_r) begin
          if (cnt_r <= 10'h001) begin
            cnt_r <= 10'h000;
            dir_down_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end else if ({1'b0, cnt_r} >= top) begin
          cnt_r <= cnt_r - 10'h001;
          dir_down_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 10'h001;
        end
      end else if (mode_pwm) begin
        cnt_r <= edge_end ? 10'h000 : cnt_r + 10'h001;
      end else if (ctrl_a_r.counter_clear_select ? a_hit : p_hit) begin
        cnt_r <= 10'h000;
      end else begin
        cnt_r <= cnt_r + 10'h001; // Overflow wraps to zero
      end
    end
  end

  // Compare-mode pin states; P matches never reach them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_a_r <= 1'b0;
      st_b_r <= 1'b0;
    end else if (run_rise) begin
      st_a_r <= ctrl_a_r.pin_a_initial_level;
      st_b_r <= ctrl_b_r.pin_b_initial_level;
    end else if (mode_cmp) begin
      if (ev_a) st_a_r <= cmp_action(ctrl_a_r.pin_a_action, st_a_r);
      if (ev_b) st_b_r <= cmp_action(ctrl_b_r.pin_b_action, st_b_r);
    end
  end

  // Registered pin drive; pin A is left undriven in PWM mode when it sets the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r <= ept_pins_t'(6'h00);
    end else begin
      pins_r.pin_a_oe <= mode_cmp ||
                         (mode_pwm && !ctrl_a_r.counter_clear_select);
      pins_r.pins_b_oe <= mode_cmp || mode_pwm;
      if (mode_pwm) begin
        pins_r.output_pin_a <= pwm_level(ctrl_a_r.pin_a_action,
          ctrl_a_r.pin_a_initial_level, wave_a, ctrl_a_r.pin_a_invert);
        pins_r.output_pins_b <= {3{pwm_level(ctrl_b_r.pin_b_action,
          ctrl_b_r.pin_b_initial_level, wave_b, ctrl_b_r.pin_b_invert)}};
      end else begin
        pins_r.output_pin_a <= st_a_r ^ ctrl_a_r.pin_a_invert;
        pins_r.output_pins_b <= {3{st_b_r ^ ctrl_b_r.pin_b_invert}};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pins = pins_r;

  // Checks on counting, flags and pins
  a_cmp_p_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_cmp && tick && !run_rise && !ctrl_a_r.counter_clear_select &&
     p_hit) |=> (cnt_r == 10'h000) && flags_r.match_p_flag)
    else $error("compare mode P match did not clear counter");
  a_no_p_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_a_r.counter_clear_select && !centre && !flags_r.match_p_flag &&
     !wr_en) |=> !flags_r.match_p_flag)
    else $error("P flag set while clear select high");
  a_pin_steady: assert property (@(posedge pclk) disable iff (!presetn)
    (!run_rise && !ev_a) |=> $stable(st_a_r))
    else $error("pin A state moved without an A match");
  a_toggle_act: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_cmp && ev_a && !run_rise &&
     ctrl_a_r.pin_a_action == ACT_TOGGLE) |=> st_a_r != $past(st_a_r))
    else $error("toggle action did not toggle pin A");
  a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
    run_rise |=> st_b_r == $past(ctrl_b_r.pin_b_initial_level))
    else $error("run edge did not load pin B initial level");
  a_timer_undriven: assert property (@(posedge pclk) disable iff (!presetn)
    mode_tmr |=> !pins_r.pin_a_oe && !pins_r.pins_b_oe)
    else $error("pins driven in timer mode");
  a_edge_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_pwm && !centre && tick && !run_rise && edge_end) |=>
    cnt_r == 10'h000)
    else $error("edge PWM counter did not return to zero");
  a_full_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_pwm && ctrl_b_r.pin_b_action == PACT_WAVE &&
     {1'b0, cmp_b_r} >= top) |=> pins_r.output_pins_b[0] ==
    ($past(ctrl_b_r.pin_b_initial_level) ^ $past(ctrl_b_r.pin_b_invert)))
    else $error("duty at or above period not full");
  a_hold_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");
  a_centre_p: assert property (@(posedge pclk) disable iff (!presetn)
    (centre && tick && !run_rise && dir_down_r && cnt_r == 10'h001) |=>
    ##[0:1] flags_r.match_p_flag)
    else $error("centre P flag missing at zero");

  c_cmp_toggle: cover property (@(posedge pclk) disable iff (!presetn)
    mode_cmp && ev_a && ctrl_a_r.pin_a_action == ACT_TOGGLE);
  c_edge_wrap: cover property (@(posedge pclk) disable iff (!presetn)
    mode_pwm && !centre && tick && edge_end);
  c_centre_turn: cover property (@(posedge pclk) disable iff (!presetn)
    centre && tick && dir_down_r && cnt_r == 10'h001);
  c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_FLAGS && flags_r != ept_flags_t'(3'h0));

endmodule : ept_timer

/* verification/ept_load.sv */
// Load model that watches the timer output pins
`timescale 1ns/1ps
module ept_load (
  input wire logic pclk, // Bench clock
  input wire logic presetn, // Async reset, active low
  input wire ept_pkg::ept_pins_t pins, // Pins from the timer
  input wire logic measure, // Count high samples while set
  output int hi_a, // High samples seen on pin A
  output int hi_b // High samples seen on pins B
);
  import ept_pkg::*;
  logic lvl_a;
  logic lvl_b;
  logic meas_q;
  // Undriven pins fall to the pull-down level, so a missing oe reads low
  assign lvl_a = pins.pin_a_oe & pins.output_pin_a;
  assign lvl_b = pins.pins_b_oe & (&pins.output_pins_b);
  // Counts restart when a window opens; no windowing of partial periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_a <= 0;
      hi_b <= 0;
      meas_q <= 1'b0;
    end else begin
      meas_q <= measure;
      if (measure && !meas_q) begin
        hi_a <= int'(lvl_a);
        hi_b <= int'(lvl_b);
      end else if (measure) begin
        hi_a <= hi_a + int'(lvl_a);
        hi_b <= hi_b + int'(lvl_b);
      end
    end
  end
endmodule : ept_load

/* verification/testbench.sv */
// Self-checking bench for the compare/PWM timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("Error %s expected %h seen %h", nm, ex, got); err_count++; end end
module testbench;
  import ept_pkg::*;
  typedef struct {
    logic cs; logic [2:0] fld; logic [1:0] aln;
    logic [9:0] cav; logic [9:0] cbv; logic [1:0] aa; logic [1:0] ab;
    logic inv; int win; int ea; int eb; logic chka; logic [3:0] ef;
  } ept_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ept_pins_t pins;
  logic measure = 1'b0;
  int hi_a;
  int hi_b;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [31:0] q2;
  logic e;
  ept_row_t rows [5];
  ept_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins));
  ept_load load (.pclk(pclk), .presetn(presetn), .pins(pins),
    .measure(measure), .hi_a(hi_a), .hi_b(hi_b));
  // 100 MHz clock
  always #5 pclk = ~pclk;
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // One APB transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, q)
  endtask : rchk
  function automatic logic [31:0] ca(input logic run, input logic [1:0] md,
      input logic [1:0] act, input logic ini, input logic inv,
      input logic cs, input logic [2:0] fld);
    ept_ctrl_a_t c;
    c = '{period_field: fld, counter_clear_select: cs, pin_a_invert: inv,
          pin_a_initial_level: ini, pin_a_action: act,
          compare_a_mode_pair: md, timer_run_enable: run};
    return {21'h0, c};
  endfunction : ca
  function automatic logic [31:0] cb(input logic [1:0] md,
      input logic [1:0] act, input logic ini, input logic inv,
      input logic [1:0] aln);
    ept_ctrl_b_t c;
    c = '{pwm_align_select: aln, pin_b_invert: inv,
          pin_b_initial_level: ini, pin_b_action: act,
          compare_b_mode_pair: md};
    return {24'h0, c};
  endfunction : cb
  // Main sequence
  initial begin
    rows = '{
      '{1'b0, 3'h1, ALN_EDGE, 10'h020, 10'h0c8, PACT_WAVE, PACT_WAVE, 1'b0,
        32'h100, 32'h40, 32'h100, 1'b1, 4'h5},
      '{1'b0, 3'h1, ALN_EDGE, 10'h020, 10'h080, PACT_WAVE, PACT_INACTIVE,
        1'b1, 32'h100, 32'hc0, 32'h0, 1'b1, 4'h5},
      '{1'b1, 3'h0, ALN_EDGE, 10'h032, 10'h00a, PACT_INACTIVE, PACT_WAVE,
        1'b0, 32'h1f4, 32'h0, 32'h64, 1'b0, 4'h3},
      '{1'b1, 3'h0, ALN_UP, 10'h00a, 10'h004, PACT_INACTIVE, PACT_WAVE,
        1'b0, 32'hc8, 32'h0, 32'h46, 1'b0, 4'h7},
      '{1'b0, 3'h1, ALN_DOWN, 10'h010, 10'h028, PACT_WAVE, PACT_ACTIVE,
        1'b0, 32'h200, 32'h3e, 32'h200, 1'b1, 4'h7}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-back width and an unmapped address
    rchk("ctrl_a_rst", OFS_CTRL_A, {21'h0, CTRL_A_RST});
    rchk("cmp_a_rst", OFS_CMP_A, {22'h0, CMP_RST});
    rchk("pins_rst", OFS_PINS, 32'h11);
    wr(OFS_CMP_A, 32'hffffffff);
    rchk("cmp_a_width", OFS_CMP_A, 32'h3ff);
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    $display("test registers done");
    // Compare mode, clear on A: no P flag, set and clear actions
    wr(OFS_PRESC, 32'h0);
    wr(OFS_CMP_A, 32'h1e);
    wr(OFS_CMP_B, 32'h14);
    wr(OFS_CTRL_B, cb(MODE_CMP, ACT_HIGH, 1'b0, 1'b0, ALN_EDGE));
    wr(OFS_CTRL_A, ca(1'b1, MODE_CMP, ACT_LOW, 1'b1, 1'b0, 1'b1, 3'h0));
    repeat (2) @(posedge pclk);
    rchk("pins_init", OFS_PINS, 32'h31);
    repeat (40) @(posedge pclk);
    rchk("flags_clr_a", OFS_FLAGS, 32'h3);
    rchk("pins_match", OFS_PINS, 32'h1f);
    wr(OFS_CTRL_A, ca(1'b0, MODE_CMP, ACT_LOW, 1'b1, 1'b0, 1'b1, 3'h0));
    wr(OFS_FLAGS, 32'h7);
    rchk("flags_w1c", OFS_FLAGS, 32'h0);
    $display("test compare_clear_a done");
    // Clear on P with a 128 period: P flag, keep and toggle actions
    wr(OFS_CMP_A, 32'h64);
    wr(OFS_CMP_B, 32'h14);
    wr(OFS_CTRL_B, cb(MODE_CMP, ACT_KEEP, 1'b1, 1'b0, ALN_EDGE));
    wr(OFS_CTRL_A, ca(1'b1, MODE_CMP, ACT_TOGGLE, 1'b1, 1'b0, 1'b0, 3'h1));
    repeat (180) @(posedge pclk);
    rchk("flags_clr_p", OFS_FLAGS, 32'h7);
    rchk("pins_toggle", OFS_PINS, 32'h1f);
    wr(OFS_CTRL_A, ca(1'b0, MODE_CMP, ACT_KEEP, 1'b1, 1'b0, 1'b0, 3'h1));
    apb(1'b0, OFS_COUNT, 32'h0);
    q2 = q;
    repeat (10) @(posedge pclk);
    rchk("count_hold", OFS_COUNT, q2);
    $display("test compare_clear_p done");
    // Timer/counter mode: same flags, pins not driven
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CTRL_B, cb(MODE_TMR, ACT_HIGH, 1'b0, 1'b0, ALN_EDGE));
    wr(OFS_CTRL_A, ca(1'b1, MODE_TMR, ACT_HIGH, 1'b0, 1'b0, 1'b0, 3'h1));
    repeat (180) @(posedge pclk);
    rchk("flags_timer", OFS_FLAGS, 32'h7);
    `CHK("oe_a_timer", 1'b0, pins.pin_a_oe)
    `CHK("oe_b_timer", 1'b0, pins.pins_b_oe)
    $display("test timer done");
    // PWM table: duty measured by the load over whole periods
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_FLAGS, 32'h7);
      wr(OFS_CMP_A, {22'h0, rows[i].cav});
      wr(OFS_CMP_B, {22'h0, rows[i].cbv});
      wr(OFS_CTRL_B, cb(MODE_PWM, rows[i].ab, 1'b1, 1'b0, rows[i].aln));
      wr(OFS_CTRL_A, ca(1'b1, MODE_PWM, rows[i].aa, 1'b1, rows[i].inv,
                        rows[i].cs, rows[i].fld));
      repeat (600) @(posedge pclk);
      measure <= 1'b1;
      repeat (rows[i].win) @(posedge pclk);
      measure <= 1'b0;
      repeat (2) @(posedge pclk);
      if (rows[i].chka) `CHK("pwm_a_high", rows[i].ea, hi_a)
      `CHK("pwm_b_high", rows[i].eb, hi_b)
      if (!rows[i].ef[3]) rchk("pwm_flags", OFS_FLAGS, {29'h0, rows[i].ef[2:0]});
      `CHK("pins_b_same", {3{pins.output_pins_b[0]}}, pins.output_pins_b)
      $display("test pwm row %0d done", i);
    end
    finish_test();
  end
endmodule : testbench
